/* hdl/jtb_fifo.sv */
// jtb_fifo: synchronous fifo with valid/ready on both sides
// assumes: single clock, DEPTH a power of two
module jtb_fifo
  import jtb_pkg::*;
#(
  parameter int W = JTB_BSR_LEN_DEF,
  parameter int DEPTH = JTB_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  logic full;
  logic empty;

  // ==========================================================
  // flags
  assign empty = (wr_reg == rd_reg);
  assign full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_reg[AW-1:0]];

  // ==========================================================
  // storage and pointers
  always_ff @(posedge clk_i) begin
    if (in_valid_i && !full) begin
      mem[wr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (in_valid_i && !full) begin
        wr_reg <= wr_reg + (AW+1)'(1);
      end
      if (out_ready_i && !empty) begin
        rd_reg <= rd_reg + (AW+1)'(1);
      end
    end
  end

endmodule // jtb_fifo

/* hdl/jtb_sync.sv */
// jtb_sync: three-flop synchroniser with agreement filter per bit
// assumes: inputs are asynchronous to clk_i
module jtb_sync
  import jtb_pkg::*;
#(
  parameter int W = JTB_PIN_CNT
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // ==========================================================
  // per bit: three stages, level taken when stage 2 and 3 agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic q_reg;
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        s1_reg <= 1'h0;
        s2_reg <= 1'h0;
        s3_reg <= 1'h0;
        q_reg <= 1'h0;
      end else begin
        s1_reg <= d_i[i];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg) begin
          q_reg <= s3_reg;
        end
      end
    end
    assign q_o[i] = q_reg;
  end

endmodule // jtb_sync

/* hdl/jtb_tap.sv */
// jtb_tap: boundary-scan test access port, controller and registers
// assumes: test pins are asynchronous, sampled by clk_i; pin samples
// arrive as a stream, functional outputs come from the core
//
// Function
// - exit1-dr with mode low goes to pause-dr, data registers hold
// - pause-dr holds shifting while mode low, high goes to exit2-dr
// - exit2-dr: high goes to update-dr, low back to shift-dr
// - update-dr copies boundary shift into output latch on falling edge only
// - from either update state: high to select-dr, low to run-test/idle
// - capture-ir loads 01; high to exit1-ir, low to shift-ir
// - shift-ir shifts instruction bits one per rising edge, high exits
// - exit1-ir: high goes to update-ir, low to pause-ir
// - pause-ir holds instruction shift while mode low, high to exit2-ir
// - exit2-ir: high goes to update-ir, low back to shift-ir
// - update-ir latches shifted instruction on falling edge, becomes current
// - data registers hold except during their capture, shift, update
// - state changes only on rising test clock or test reset
// - serial out driven only in shift states, else released, on falling edge
// - system reset never initialises the controller
// - five rising edges with mode high reach test-logic-reset
// - active-low test reset forces test-logic-reset asynchronously
// - instruction latch changes only in update-ir and reset state
// - instruction bits uninverted, shifted out lsb first on falling edges
// - decode 00 extest, 01 sample/preload, 10 and 11 bypass
// - extest drives outputs from update latch, captures inputs at capture-dr
// - code 01 gives both sample and preload
// - bypass is one shift stage between serial in and out
// - capture-dr loads pin values in parallel on rising edge
module jtb_tap
  import jtb_pkg::*;
#(
  parameter int BSR_LEN = JTB_BSR_LEN_DEF
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic test_clock_in_i,
  input wire logic test_mode_select_i,
  input wire logic test_serial_in_i,
  input wire logic test_reset_n_i,
  output logic test_serial_out_o,
  output logic test_serial_out_oe_n_o,
  input wire logic [BSR_LEN-1:0] cap_data_i,
  input wire logic cap_valid_i,
  output logic cap_ready_o,
  input wire logic [BSR_LEN-1:0] core_out_i,
  output logic [BSR_LEN-1:0] pin_out_o,
  output logic [1:0] instr_o
);

  // ==========================================================
  // pin sampling and test clock edges
  logic [JTB_PIN_CNT-1:0] pins_f;
  logic tck_f;
  logic tms_f;
  logic tdi_f;
  logic tck_q_reg;
  logic rise;
  logic fall;

  jtb_sync #(.W(JTB_PIN_CNT)) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i({test_serial_in_i, test_mode_select_i, test_clock_in_i}),
    .q_o(pins_f)
  );

  assign tck_f = pins_f[0];
  assign tms_f = pins_f[1];
  assign tdi_f = pins_f[2];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tck_q_reg <= 1'h0;
    end else begin
      tck_q_reg <= tck_f;
    end
  end

  assign rise = tck_f && !tck_q_reg;
  assign fall = !tck_f && tck_q_reg;

  // ==========================================================
  // controller
  jtb_state_t state_reg;
  jtb_state_t state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      JTB_TLR: state_next = tms_f ? JTB_TLR : JTB_RTI;
      JTB_RTI: state_next = tms_f ? JTB_SEL_DR : JTB_RTI;
      JTB_SEL_DR: state_next = tms_f ? JTB_SEL_IR : JTB_CAP_DR;
      JTB_CAP_DR: state_next = tms_f ? JTB_EXIT1_DR : JTB_SHIFT_DR;
      JTB_SHIFT_DR: state_next = tms_f ? JTB_EXIT1_DR : JTB_SHIFT_DR;
      JTB_EXIT1_DR: state_next = tms_f ? JTB_UPD_DR : JTB_PAUSE_DR;
      JTB_PAUSE_DR: state_next = tms_f ? JTB_EXIT2_DR : JTB_PAUSE_DR;
      JTB_EXIT2_DR: state_next = tms_f ? JTB_UPD_DR : JTB_SHIFT_DR;
      JTB_UPD_DR: state_next = tms_f ? JTB_SEL_DR : JTB_RTI;
      JTB_SEL_IR: state_next = tms_f ? JTB_TLR : JTB_CAP_IR;
      JTB_CAP_IR: state_next = tms_f ? JTB_EXIT1_IR : JTB_SHIFT_IR;
      JTB_SHIFT_IR: state_next = tms_f ? JTB_EXIT1_IR : JTB_SHIFT_IR;
      JTB_EXIT1_IR: state_next = tms_f ? JTB_UPD_IR : JTB_PAUSE_IR;
      JTB_PAUSE_IR: state_next = tms_f ? JTB_EXIT2_IR : JTB_PAUSE_IR;
      JTB_EXIT2_IR: state_next = tms_f ? JTB_UPD_IR : JTB_SHIFT_IR;
      JTB_UPD_IR: state_next = tms_f ? JTB_SEL_DR : JTB_RTI;
      default: state_next = JTB_TLR;
    endcase
  end

  // only the test reset initialises the controller
  always_ff @(posedge clk_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      state_reg <= JTB_TLR;
    end else if (rise) begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // instruction register
  logic [1:0] ir_sh_reg;
  logic [1:0] ir_reg;
  logic sel_bypass;
  logic sel_bsr;
  logic extest;

  always_ff @(posedge clk_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      ir_sh_reg <= JTB_IR_SH_RST;
    end else if (state_reg == JTB_TLR) begin
      ir_sh_reg <= JTB_IR_SH_RST;
    end else if (rise && state_reg == JTB_CAP_IR) begin
      ir_sh_reg <= JTB_IR_CAPTURE;
    end else if (rise && state_reg == JTB_SHIFT_IR) begin
      ir_sh_reg <= {tdi_f, ir_sh_reg[1]};
    end
  end

  always_ff @(posedge clk_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      ir_reg <= JTB_IR_LATCH_RST;
    end else if (state_reg == JTB_TLR) begin
      ir_reg <= JTB_IR_LATCH_RST;
    end else if (fall && state_reg == JTB_UPD_IR) begin
      ir_reg <= ir_sh_reg;
    end
  end

  // decode: both 1x codes select bypass
  assign sel_bypass = ir_reg[1];
  assign sel_bsr = !ir_reg[1];
  assign extest = (ir_reg == JTB_IR_EXTEST);
  assign instr_o = ir_reg;

  // ==========================================================
  // bypass register
  logic byp_reg;

  always_ff @(posedge clk_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      byp_reg <= JTB_BYP_CAPTURE;
    end else if (rise && sel_bypass && state_reg == JTB_CAP_DR) begin
      byp_reg <= JTB_BYP_CAPTURE;
    end else if (rise && sel_bypass && state_reg == JTB_SHIFT_DR) begin
      byp_reg <= tdi_f;
    end
  end

  // ==========================================================
  // pin sample stream into capture
  logic [BSR_LEN-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic [BSR_LEN-1:0] samp_reg;
  logic [BSR_LEN-1:0] cap_src;

  assign fifo_pop = rise && sel_bsr && state_reg == JTB_CAP_DR && fifo_valid;

  jtb_fifo #(.W(BSR_LEN), .DEPTH(JTB_FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_data_i(cap_data_i),
    .in_valid_i(cap_valid_i),
    .in_ready_o(cap_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  // last sample held when no newer one waits
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      samp_reg <= '0;
    end else if (fifo_pop) begin
      samp_reg <= fifo_data;
    end
  end

  assign cap_src = fifo_valid ? fifo_data : samp_reg;

  // ==========================================================
  // boundary-scan register
  logic [BSR_LEN-1:0] bsr_sh_reg;
  logic [BSR_LEN-1:0] bsr_upd_reg;

  always_ff @(posedge clk_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      bsr_sh_reg <= '0;
    end else if (rise && sel_bsr && state_reg == JTB_CAP_DR) begin
      bsr_sh_reg <= cap_src;
    end else if (rise && sel_bsr && state_reg == JTB_SHIFT_DR) begin
      bsr_sh_reg <= {tdi_f, bsr_sh_reg[BSR_LEN-1:1]};
    end
  end

  always_ff @(posedge clk_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      bsr_upd_reg <= '0;
    end else if (fall && sel_bsr && state_reg == JTB_UPD_DR) begin
      bsr_upd_reg <= bsr_sh_reg;
    end
  end

  // system outputs: latch under extest, core otherwise
  logic [BSR_LEN-1:0] pin_out_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_out_reg <= '0;
    end else begin
      pin_out_reg <= extest ? bsr_upd_reg : core_out_i;
    end
  end

  assign pin_out_o = pin_out_reg;

  // ==========================================================
  // serial output driver
  logic tdo_reg;
  logic oe_n_reg;

  always_ff @(posedge clk_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      tdo_reg <= JTB_TDO_RST;
      oe_n_reg <= JTB_OE_N_RST;
    end else if (fall) begin
      oe_n_reg <= !(state_reg == JTB_SHIFT_IR || state_reg == JTB_SHIFT_DR);
      if (state_reg == JTB_SHIFT_IR) begin
        tdo_reg <= ir_sh_reg[0];
      end else if (sel_bsr) begin
        tdo_reg <= bsr_sh_reg[0];
      end else begin
        tdo_reg <= byp_reg;
      end
    end
  end

  assign test_serial_out_o = tdo_reg;
  assign test_serial_out_oe_n_o = oe_n_reg;

  // ==========================================================
  // checks
  logic [2:0] hi_cnt_reg;

  always_ff @(posedge clk_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      hi_cnt_reg <= 3'h0;
    end else if (rise) begin
      if (!tms_f) begin
        hi_cnt_reg <= 3'h0;
      end else if (hi_cnt_reg != JTB_RESET_RISES) begin
        hi_cnt_reg <= hi_cnt_reg + 3'h1;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i || !test_reset_n_i);

  chk_exit1_pause: assert property (
    rise && state_reg == JTB_EXIT1_DR && !tms_f |=> state_reg == JTB_PAUSE_DR
      && $stable(bsr_sh_reg) && $stable(byp_reg))
    else $error("exit1-dr low did not reach pause-dr");

  chk_pause_dr_hold: assert property (
    state_reg == JTB_PAUSE_DR && !(rise && tms_f) |=> state_reg == JTB_PAUSE_DR
      && $stable(bsr_sh_reg))
    else $error("pause-dr did not hold");

  chk_exit2dr_next: assert property (
    rise && state_reg == JTB_EXIT2_DR |=>
      state_reg == ($past(tms_f) ? JTB_UPD_DR : JTB_SHIFT_DR))
    else $error("exit2-dr went to a wrong state");

  chk_upd_latch_when: assert property (
    $changed(bsr_upd_reg) |-> $past(state_reg) == JTB_UPD_DR && $past(fall))
    else $error("output latch changed outside update-dr fall");

  chk_capture_ir_load: assert property (
    rise && state_reg == JTB_CAP_IR |=> ir_sh_reg == JTB_IR_CAPTURE)
    else $error("capture-ir did not load 01");

  chk_state_on_rise: assert property (
    $changed(state_reg) |-> $past(rise))
    else $error("state changed without rising test clock");

  chk_tdo_released: assert property (
    fall && state_reg != JTB_SHIFT_IR && state_reg != JTB_SHIFT_DR |=>
      test_serial_out_oe_n_o ##1 test_serial_out_oe_n_o)
    else $error("serial out driven outside shift");

  chk_five_high_reset: assert property (
    rise && tms_f && hi_cnt_reg >= JTB_RESET_RISES - 3'h1 |=> state_reg == JTB_TLR)
    else $error("five high rises did not reach reset state");

  chk_ir_latch_when: assert property (
    $changed(ir_reg) |-> $past(state_reg) == JTB_TLR
      || ($past(state_reg) == JTB_UPD_IR && $past(fall)))
    else $error("instruction changed outside update-ir or reset");

  chk_extest_drive: assert property (
    extest |=> pin_out_o == $past(bsr_upd_reg))
    else $error("extest outputs not from latch");

  chk_pause_ir_hold: assert property (
    state_reg == JTB_PAUSE_IR && !(rise && tms_f) |=> state_reg == JTB_PAUSE_IR
      && $stable(ir_sh_reg))
    else $error("pause-ir did not hold");

  chk_exit1ir_next: assert property (
    rise && state_reg == JTB_EXIT1_IR |=>
      state_reg == ($past(tms_f) ? JTB_UPD_IR : JTB_PAUSE_IR))
    else $error("exit1-ir went to a wrong state");

  chk_exit2ir_next: assert property (
    rise && state_reg == JTB_EXIT2_IR |=>
      state_reg == ($past(tms_f) ? JTB_UPD_IR : JTB_SHIFT_IR))
    else $error("exit2-ir went to a wrong state");

  chk_update_next: assert property (
    rise && (state_reg == JTB_UPD_DR || state_reg == JTB_UPD_IR) |=>
      state_reg == ($past(tms_f) ? JTB_SEL_DR : JTB_RTI))
    else $error("update state went to a wrong state");

  chk_bypass_shift: assert property (
    rise && sel_bypass && state_reg == JTB_SHIFT_DR |=> byp_reg == $past(tdi_f))
    else $error("bypass stage did not take serial in");

  cov_shift_dr: cover property (rise && state_reg == JTB_SHIFT_DR && tms_f);
  cov_update_ir: cover property (fall && state_reg == JTB_UPD_IR);
  cov_pause_ir: cover property (state_reg == JTB_PAUSE_IR && rise && tms_f);
  cov_extest: cover property (extest && fall && state_reg == JTB_UPD_DR);

endmodule // jtb_tap

/* include/jtb_pkg.sv */
// jtb_pkg: shared constants and types of the boundary-scan test port
// assumes: included before every design file of the test port
package jtb_pkg;

  // ==========================================================
  // instruction codes
  localparam logic [1:0] JTB_IR_EXTEST = 2'h0;
  localparam logic [1:0] JTB_IR_SAMPLE = 2'h1;
  localparam logic [1:0] JTB_IR_BYP_LO = 2'h2;
  localparam logic [1:0] JTB_IR_BYPASS = 2'h3;
  localparam logic [1:0] JTB_IR_CAPTURE = 2'h1;
  localparam int JTB_IR_LEN = 2;

  // ==========================================================
  // reset values
  localparam logic [1:0] JTB_IR_SH_RST = 2'h1;
  localparam logic [1:0] JTB_IR_LATCH_RST = JTB_IR_BYPASS;
  localparam logic JTB_BYP_CAPTURE = 1'h0;
  localparam logic JTB_TDO_RST = 1'h0;
  localparam logic JTB_OE_N_RST = 1'h1;

  // ==========================================================
  // sizes
  localparam int JTB_BSR_LEN_DEF = 8;
  localparam int JTB_FIFO_DEPTH = 16;
  localparam int JTB_PIN_CNT = 3;
  localparam logic [2:0] JTB_RESET_RISES = 3'h5;

  // ==========================================================
  // controller states
  typedef enum logic [3:0] {
    JTB_TLR, JTB_RTI, JTB_SEL_DR, JTB_CAP_DR, JTB_SHIFT_DR, JTB_EXIT1_DR,
    JTB_PAUSE_DR, JTB_EXIT2_DR, JTB_UPD_DR, JTB_SEL_IR, JTB_CAP_IR,
    JTB_SHIFT_IR, JTB_EXIT1_IR, JTB_PAUSE_IR, JTB_EXIT2_IR, JTB_UPD_IR
  } jtb_state_t;

endpackage

/* tb/jtb_tap_tb.sv */
// jtb_tap_tb: self-checking bench of the boundary-scan test port
// assumes: jtb_pkg compiled first; tester model drives the test pins
module jtb_tap_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import jtb_pkg::*;

  // ==========================================================
  // signals and instances
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic tck, tms, tdi, trst_n, tdo, oe_n, cap_valid, cap_ready;
  logic [7:0] cap_data, core_out, pin_out;
  logic [1:0] instr;
  logic [31:0] tdo_b, oe_b;
  int fail_count = 0;
  int check_count = 0;

  initial begin
    forever #25 clk = ~clk;
  end

  jtb_tap #(.BSR_LEN(8)) i_jtb_tap (
    .clk_i(clk), .rstn_i(rstn), .test_clock_in_i(tck), .test_mode_select_i(tms),
    .test_serial_in_i(tdi), .test_reset_n_i(trst_n), .test_serial_out_o(tdo),
    .test_serial_out_oe_n_o(oe_n), .cap_data_i(cap_data), .cap_valid_i(cap_valid),
    .cap_ready_o(cap_ready), .core_out_i(core_out), .pin_out_o(pin_out), .instr_o(instr)
  );

  jtb_tester i_jtb_tester (
    .clk_i(clk), .tdo_i(tdo), .oe_n_i(oe_n), .tck_o(tck), .tms_o(tms),
    .tdi_o(tdi), .trst_n_o(trst_n)
  );

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // steps of a data scan that carry shifted bits
  function automatic logic [31:0] place(input logic [7:0] d);
    return ({27'h0, d[4:0]} << 3) | ({29'h0, d[7:5]} << 12);
  endfunction

  task automatic push(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      cap_data = base + 8'(i * 17);
      cap_valid = 1'b1;
      @(posedge clk);
      #2;
    end
    cap_valid = 1'b0;
  endtask

  // from run-test/idle, with a pause-ir detour
  task automatic load_ir(input logic [1:0] code);
    i_jtb_tester.scan(11, 32'h323, {26'h0, code, 4'h0}, tdo_b, oe_b);
    chk(tdo_b[5:4], 32'h1);
    chk(oe_b[6:3], 32'h9);
    chk(instr, code);
  endtask

  // from run-test/idle, eight shifts with a pause-dr detour
  task automatic dr_scan(input logic [7:0] d);
    logic [31:0] m;
    m = place(8'hFF);
    i_jtb_tester.scan(17, 32'hC481, place(d), tdo_b, oe_b);
    tdo_b = tdo_b & m;
    chk(oe_b & 32'h1FFFC, ~m & 32'h1FFFC);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    fork
      i_jtb_tester.hold_reset(20);
      begin
        repeat (20) @(posedge clk);
        #2;
        rstn = 1'b1;
      end
    join
    chk(instr, 32'h3);
    chk(oe_n, 32'h1);
    chk(cap_ready, 32'h1);
    i_jtb_tester.scan(1, 32'h0, 32'h0, tdo_b, oe_b);
    $display("test reset done");
  endtask

  task automatic t_ir_codes();
    for (int c = 0; c < 4; c++) begin
      load_ir(2'(c));
    end
    $display("test ir_codes done");
  endtask

  task automatic t_bypass();
    for (int c = 2; c < 4; c++) begin
      load_ir(2'(c));
      dr_scan(8'h96);
      chk(tdo_b, place({8'h96 << 1}));
      chk(pin_out, core_out);
    end
    $display("test bypass done");
  endtask

  task automatic t_sample();
    push(1, 8'h5A);
    load_ir(2'h1);
    dr_scan(8'hC3);
    chk(tdo_b, place(8'h5A));
    chk(pin_out, core_out);
    load_ir(2'h0);
    chk(pin_out, 32'hC3);
    $display("test sample done");
  endtask

  task automatic t_extest();
    push(1, 8'hA5);
    dr_scan(8'h3C);
    chk(tdo_b, place(8'hA5));
    chk(pin_out, 32'h3C);
    $display("test extest done");
  endtask

  task automatic t_mode_reset();
    rstn = 1'b0;
    repeat (20) @(posedge clk);
    #2;
    rstn = 1'b1;
    chk(instr, 32'h0);
    i_jtb_tester.scan(8, 32'hF9, 32'h0, tdo_b, oe_b);
    chk(oe_b[3], 32'h0);
    chk(instr, 32'h3);
    chk(oe_n, 32'h1);
    i_jtb_tester.scan(1, 32'h0, 32'h0, tdo_b, oe_b);
    $display("test mode_reset done");
  endtask

  task automatic t_fifo();
    load_ir(2'h1);
    push(16, 8'h00);
    chk(cap_ready, 32'h0);
    @(posedge clk);
    #2;
    push(1, 8'h77);
    for (int i = 0; i < 15; i++) begin
      i_jtb_tester.scan(5, 32'h0D, 32'h0, tdo_b, oe_b);
    end
    chk(cap_ready, 32'h1);
    dr_scan(8'h00);
    chk(tdo_b, place(8'hFF));
    // empty fifo: last popped word captured again
    dr_scan(8'h00);
    chk(tdo_b, place(8'hFF));
    $display("test fifo done");
  endtask

  // capture-ir exit, exit2-ir back to shift, update-ir high, exit2-dr to update
  task automatic t_paths();
    push(1, 8'h69);
    i_jtb_tester.scan(17, 32'h0D72B, 32'h0, tdo_b, oe_b);
    chk(tdo_b[8:7], 32'h1);
    chk(oe_b[9:6], 32'h9);
    chk(instr, 32'h0);
    chk(pin_out, 32'h69);
    $display("test paths done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    cap_data = 8'h00;
    cap_valid = 1'b0;
    core_out = 8'h81;
    #2;
    t_reset();
    t_ir_codes();
    t_bypass();
    t_sample();
    t_extest();
    t_mode_reset();
    t_fifo();
    t_paths();
    close_out();
  end

  initial begin
    #2_000_000;
    fail_count++;
    $display("BAD t=%0t got=%0h exp=%0h", $time, 0, 1);
    close_out();
  end
endmodule // jtb_tap_tb

/* tb/jtb_tester.sv */
// jtb_tester: behavioural boundary-scan tester facing the test port
// assumes: clk_i is the system clock; calls start just after its rising edge
module jtb_tester (
  input wire logic clk_i,
  input wire logic tdo_i,
  input wire logic oe_n_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // serial out line level
  logic last_reg = 1'b0;
  logic line_lvl;

  // released line shows inverse of last driven value
  always @(posedge clk_i) begin
    if (!oe_n_i) begin
      last_reg <= tdo_i;
    end
  end
  assign line_lvl = oe_n_i ? ~last_reg : tdo_i;

  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_n_o = 1'b0;
  end

  // ==========================================================
  // pin sequences
  task automatic hold_reset(input int cycles);
    trst_n_o = 1'b0;
    repeat (cycles) @(posedge clk_i);
    #2;
    trst_n_o = 1'b1;
    repeat (4) @(posedge clk_i);
    #2;
  endtask

  // test clock runs only inside a scan, 400 ns period
  task automatic scan(input int n, input logic [31:0] tms_b, input logic [31:0] tdi_b,
                      output logic [31:0] tdo_b, output logic [31:0] oe_b);
    tdo_b = '0;
    oe_b = '0;
    for (int i = 0; i < n; i++) begin
      tms_o = tms_b[i];
      tdi_o = tdi_b[i];
      #200;
      tck_o = 1'b1;
      #100;
      tdo_b[i] = line_lvl;
      oe_b[i] = oe_n_i;
      #100;
      tck_o = 1'b0;
    end
    #300;
  endtask
endmodule // jtb_tester
